// File: sapx_exc.v
`timescale 1ns/1ns
// Behaviour
// RULE1: Data storage fault on access, byte-order or cache-lock violation, lowest of synchronous.
// RULE2: Misaligned data access crossing into page of different endianness is byte-order fault.
// RULE3: Cache lock instructions in user mode with lock enable clear fault.
// RULE4: Save full machine state as it was into save_restore_state.
// RULE5: Entry clears listed state bits, keeps critical, mchk, debug, recoverable.
// RULE6: Data fault syndrome: store, vector, var-length, byte order or lock bits only.
// RULE7: Access and byte-order faults load fault address; lock faults leave it.
// RULE8: Handler address is prefix high half, offset bits 16-27, four zeros.
// RULE9: Fetch fault on execute violation or instruction byte-order mismatch.
// RULE10: Branch to odd halfword on fixed-length page gives misaligned fetch fault.
// RULE11: Fetch fault saves instruction address, sets its syndrome bits, keeps fault address.
// RULE12: Controller holds low request level until acknowledged, else maybe unseen.
// RULE13: External interrupt only when async enable set and nothing higher pending.
// RULE14: External interrupt saves next address, keeps syndrome and fault address.
// RULE15: Non-autovectored request uses the supplied 12-bit offset instead of register.
// RULE16: Alignment fault for misaligned multiword, reservation and vector accesses.
// RULE17: Alignment fault for line-zero with cache off, write-through or inhibited.
// RULE18: Alignment fault loads fault address and store, vector, var-length syndrome.
// RULE19: Illegal instruction for illegal class, undefined register moves, unimplemented ops.
// RULE20: User mode privileged instructions and moves with register bit 5 set.
// RULE21: Trap when word trap condition met unless taken as debug.
// RULE22: Unimplemented op for string, indexed device moves, id read, float with float on.
// RULE23: Only the highest priority coexisting exception is serviced at once.
module sapx_exc (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [31:0] machine_state_i,
   input wire [31:0] vector_prefix_i,
   input wire [31:0] data_fault_offset_i,
   input wire [31:0] fetch_fault_offset_i,
   input wire [31:0] ext_irq_offset_i,
   input wire [31:0] align_offset_i,
   input wire [31:0] program_offset_i,
   input wire [31:0] instr_addr_i,
   input wire [31:0] next_addr_i,
   input wire [31:0] data_addr_i,
   input wire is_store_i,
   input wire is_vector_i,
   input wire is_var_len_i,
   input wire data_access_viol_i,
   input wire data_misaligned_i,
   input wire data_cross_page_i,
   input wire first_page_little_i,
   input wire second_page_little_i,
   input wire is_dcache_lock_op_i,
   input wire is_icache_lock_op_i,
   input wire fetch_exec_viol_i,
   input wire instr_cross_page_i,
   input wire first_page_var_len_i,
   input wire second_page_var_len_i,
   input wire fetch_page_var_len_i,
   input wire fetch_page_little_i,
   input wire flow_change_i,
   input wire target_odd_half_i,
   input wire multiword_op_i,
   input wire word_resv_op_i,
   input wire half_resv_op_i,
   input wire word_aligned_i,
   input wire half_aligned_i,
   input wire vector_misaligned_i,
   input wire line_zero_op_i,
   input wire dcache_enabled_i,
   input wire page_write_through_i,
   input wire page_inhibited_i,
   input wire illegal_class_i,
   input wire reg_move_i,
   input wire reg_undefined_i,
   input wire [9:0] special_reg_number_i,
   input wire dev_reg_undefined_i,
   input wire not_implemented_i,
   input wire privileged_op_i,
   input wire trap_op_i,
   input wire trap_cond_met_i,
   input wire trap_debug_en_i,
   input wire unimpl_op_i,
   input wire float_op_i,
   input wire ext_irq_n_i,
   input wire autovector_n_i,
   input wire [11:0] vector_offset_in_i,
   output reg take_o,
   output reg ext_ack_o,
   output reg [2:0] kind_o,
   output reg [31:0] save_restore_pc_o,
   output reg [31:0] save_restore_state_o,
   output reg [31:0] machine_state_o,
   output reg [31:0] syndrome_reg_o,
   output reg [31:0] fault_address_reg_o,
   output reg [31:0] handler_addr_o
);
`include "sapx_consts.vh"
   ////////////////////////////////////////////////////////////////////////////
   wire user_w;
   wire user_cache_lock_enable_w;
   wire ext_req_w;
   wire bo_data_w;
   wire lock_w;
   wire acc_data_w;
   wire data_w;
   wire fetch_bo_w;
   wire fetch_mif_w;
   wire fetch_w;
   wire align_w;
   wire pil_w;
   wire ppr_w;
   wire ptr_w;
   wire puo_w;
   wire prog_w;
   wire [2:0] sel_w;
   reg [31:0] syn_nxt;
   reg [11:0] off_nxt;
   reg [31:0] pc_nxt;
   reg fa_we_nxt;

   // Helper: common store, vector and var-length syndrome bits
   function [31:0] sapx_svl;
      input st;
      input vec;
      input vl;
      begin
         sapx_svl = 32'h00000000;
         sapx_svl[`SAPX_SY_ST_BIT] = st;
         sapx_svl[`SAPX_SY_SPE_BIT] = vec;
         sapx_svl[`SAPX_SY_VAR_LENGTH_INSTR_FLAG_BIT] = vl;
      end
   endfunction

   // Helper: offset field bits 16-27 of a 32-bit offset register (lsb-0 bits 15:4)
   function [11:0] sapx_off;
      input [31:0] r;
      begin
         sapx_off = r[15:4];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   assign user_w = machine_state_i[`SAPX_MS_USER_BIT];
   assign user_cache_lock_enable_w = machine_state_i[`SAPX_MS_USER_CACHE_LOCK_ENABLE_BIT];
   assign bo_data_w = data_misaligned_i & data_cross_page_i &
                      (first_page_little_i ^ second_page_little_i); // see RULE2
   assign lock_w = (is_dcache_lock_op_i | is_icache_lock_op_i) & user_w & ~user_cache_lock_enable_w; // see RULE3
   assign acc_data_w = data_access_viol_i;
   assign data_w = acc_data_w | bo_data_w | lock_w; // see RULE1
   assign fetch_bo_w = (instr_cross_page_i & (first_page_var_len_i ^ second_page_var_len_i)) |
                       (fetch_page_var_len_i & fetch_page_little_i); // see RULE9
   assign fetch_mif_w = flow_change_i & target_odd_half_i & ~fetch_page_var_len_i; // see RULE10
   assign fetch_w = fetch_exec_viol_i | fetch_bo_w | fetch_mif_w;
   assign align_w = ((multiword_op_i | word_resv_op_i) & ~word_aligned_i) |
                    (half_resv_op_i & ~half_aligned_i) | vector_misaligned_i | // see RULE16
                    (line_zero_op_i & (~dcache_enabled_i | page_write_through_i |
                                       page_inhibited_i)); // see RULE17
   assign pil_w = illegal_class_i | (reg_move_i & reg_undefined_i & 
                  ~(user_w & special_reg_number_i[`SAPX_SPECIAL_REG_NUMBER_PRIV_BIT])) |
                  dev_reg_undefined_i | not_implemented_i; // see RULE19
   assign ppr_w = user_w & (privileged_op_i |
                  (reg_move_i & special_reg_number_i[`SAPX_SPECIAL_REG_NUMBER_PRIV_BIT])); // see RULE20
   assign ptr_w = trap_op_i & trap_cond_met_i & ~trap_debug_en_i; // see RULE21
   assign puo_w = unimpl_op_i | (float_op_i & machine_state_i[`SAPX_MS_FLOAT_BIT]); // see RULE22
   assign prog_w = pil_w | ppr_w | ptr_w | puo_w;
   // Level is only looked at while held; the controller keeps it until acknowledged
   assign ext_req_w = ~ext_irq_n_i & machine_state_i[`SAPX_MS_ASYNC_BIT] &
                      ~ext_ack_o; // see RULE12, RULE13

   sapx_prio u_prio (
      .fetch_i(fetch_w),
      .prog_i(prog_w),
      .align_i(align_w),
      .data_i(data_w),
      .ext_i(ext_req_w),
      .kind_o(sel_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      syn_nxt = syndrome_reg_o;
      off_nxt = 12'h000;
      pc_nxt = instr_addr_i;
      fa_we_nxt = 1'b0;
      case (sel_w)
         `SAPX_K_FETCH: begin
            syn_nxt = 32'h00000000; // see RULE11
            syn_nxt[`SAPX_SY_BO_BIT] = fetch_bo_w;
            syn_nxt[`SAPX_SY_MIF_BIT] = fetch_mif_w;
            syn_nxt[`SAPX_SY_VAR_LENGTH_INSTR_FLAG_BIT] = is_var_len_i;
            off_nxt = sapx_off(fetch_fault_offset_i);
         end
         `SAPX_K_PROG: begin
            syn_nxt = sapx_svl(1'b0, 1'b0, is_var_len_i);
            // Only one cause is reported, the first in this order
            if (pil_w) begin
               syn_nxt[`SAPX_SY_PIL_BIT] = 1'b1;
            end else if (ppr_w) begin
               syn_nxt[`SAPX_SY_PPR_BIT] = 1'b1;
            end else if (ptr_w) begin
               syn_nxt[`SAPX_SY_PTR_BIT] = 1'b1;
            end else begin
               syn_nxt[`SAPX_SY_PUO_BIT] = 1'b1;
               syn_nxt[`SAPX_SY_FP_BIT] = float_op_i;
            end
            off_nxt = sapx_off(program_offset_i);
         end
         `SAPX_K_ALIGN: begin
            syn_nxt = sapx_svl(is_store_i, is_vector_i, is_var_len_i); // see RULE18
            fa_we_nxt = 1'b1;
            off_nxt = sapx_off(align_offset_i);
         end
         `SAPX_K_DATA: begin
            if (lock_w & ~acc_data_w & ~bo_data_w) begin
               syn_nxt = sapx_svl(is_store_i, 1'b0, is_var_len_i); // see RULE6
               syn_nxt[`SAPX_SY_DLK_BIT] = is_dcache_lock_op_i;
               syn_nxt[`SAPX_SY_ILK_BIT] = is_icache_lock_op_i;
            end else begin
               syn_nxt = sapx_svl(is_store_i, is_vector_i, is_var_len_i); // see RULE6
               syn_nxt[`SAPX_SY_BO_BIT] = bo_data_w & ~acc_data_w;
               fa_we_nxt = 1'b1; // see RULE7
            end
            off_nxt = sapx_off(data_fault_offset_i);
         end
         `SAPX_K_EXT: begin
            pc_nxt = next_addr_i; // see RULE14
            // Select is active low: negated means the controller supplies the offset
            if (autovector_n_i) begin
               off_nxt = vector_offset_in_i; // see RULE15
            end else begin
               off_nxt = sapx_off(ext_irq_offset_i);
            end
         end
         default: begin
            syn_nxt = syndrome_reg_o;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      if (rst_i) begin
         take_o <= 1'b0;
         ext_ack_o <= 1'b0;
         kind_o <= `SAPX_K_NONE;
         save_restore_pc_o <= 32'h00000000;
         save_restore_state_o <= 32'h00000000;
         machine_state_o <= 32'h00000000;
         syndrome_reg_o <= 32'h00000000;
         fault_address_reg_o <= 32'h00000000;
         handler_addr_o <= 32'h00000000;
      end else if (ce_i) begin
         take_o <= (sel_w != `SAPX_K_NONE);
         ext_ack_o <= (sel_w == `SAPX_K_EXT);
         kind_o <= sel_w;
         machine_state_o <= machine_state_i;
         if (sel_w != `SAPX_K_NONE) begin
            save_restore_pc_o <= pc_nxt;
            save_restore_state_o <= machine_state_i; // see RULE4
            machine_state_o <= machine_state_i & ~`SAPX_MS_CLR_MASK; // see RULE5
            syndrome_reg_o <= syn_nxt;
            handler_addr_o <= {vector_prefix_i[31:16], off_nxt, 4'h0}; // see RULE8
            if (fa_we_nxt) begin
               fault_address_reg_o <= data_addr_i; // see RULE7
            end
         end
      end
   end
endmodule

// File: sapx_consts.vh
`ifndef SAPX_CONSTS_VH
`define SAPX_CONSTS_VH
// Machine state bit positions, bit 0 is the lsb
`define SAPX_MS_USER_CACHE_LOCK_ENABLE_BIT 26
`define SAPX_MS_VEC_BIT 25
`define SAPX_MS_WAIT_BIT 18
`define SAPX_MS_CRIT_BIT 17
`define SAPX_MS_ASYNC_BIT 15
`define SAPX_MS_USER_BIT 14
`define SAPX_MS_FLOAT_BIT 13
`define SAPX_MS_MCHK_BIT 12
`define SAPX_MS_FE0_BIT 11
`define SAPX_MS_DBG_BIT 9
`define SAPX_MS_FE1_BIT 8
`define SAPX_MS_IS_BIT 5
`define SAPX_MS_DS_BIT 4
`define SAPX_MS_PMM_BIT 2
`define SAPX_MS_RI_BIT 1
// Bits cleared on entry
`define SAPX_MS_CLR_MASK 32'h0604E934
// Syndrome bit positions
`define SAPX_SY_PIL_BIT 27
`define SAPX_SY_PPR_BIT 26
`define SAPX_SY_PTR_BIT 25
`define SAPX_SY_FP_BIT 24
`define SAPX_SY_ST_BIT 23
`define SAPX_SY_DLK_BIT 21
`define SAPX_SY_ILK_BIT 20
`define SAPX_SY_BO_BIT 17
`define SAPX_SY_PUO_BIT 18
`define SAPX_SY_MIF_BIT 1
`define SAPX_SY_SPE_BIT 7
`define SAPX_SY_VAR_LENGTH_INSTR_FLAG_BIT 5
// Exception kind codes
`define SAPX_K_NONE 3'h0
`define SAPX_K_FETCH 3'h1
`define SAPX_K_PROG 3'h2
`define SAPX_K_ALIGN 3'h3
`define SAPX_K_DATA 3'h4
`define SAPX_K_EXT 3'h5
// Bit of a special register number that marks it privileged
`define SAPX_SPECIAL_REG_NUMBER_PRIV_BIT 5
`endif

// File: sapx_prio.v
`timescale 1ns/1ns
// Picks one exception kind; lower kinds are held back while a higher one is served
module sapx_prio (
   input wire fetch_i,
   input wire prog_i,
   input wire align_i,
   input wire data_i,
   input wire ext_i,
   output reg [2:0] kind_o
);
`include "sapx_consts.vh"
   always @* begin
      kind_o = `SAPX_K_NONE;
      if (fetch_i) begin // see RULE23
         kind_o = `SAPX_K_FETCH;
      end else if (prog_i) begin
         kind_o = `SAPX_K_PROG;
      end else if (align_i) begin
         kind_o = `SAPX_K_ALIGN;
      end else if (data_i) begin
         kind_o = `SAPX_K_DATA;
      end else if (ext_i) begin
         kind_o = `SAPX_K_EXT;
      end
   end
endmodule

// File: sapx_exc_assertions.sv
`timescale 1ns/1ns
`include "sapx_consts.vh"
// Ties each entry result to the inputs seen at the edge that took it
module sapx_exc_chk (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [31:0] machine_state_i,
   input wire [31:0] vector_prefix_i,
   input wire fetch_exec_viol_i,
   input wire ext_irq_n_i,
   input wire autovector_n_i,
   input wire [11:0] vector_offset_in_i,
   input wire take_o,
   input wire ext_ack_o,
   input wire [2:0] kind_o,
   input wire [31:0] save_restore_state_o,
   input wire [31:0] machine_state_o,
   input wire [31:0] syndrome_reg_o,
   input wire [31:0] fault_address_reg_o,
   input wire [31:0] handler_addr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ext_needs_enable: assert property (ext_ack_o |->
      $past(machine_state_i[`SAPX_MS_ASYNC_BIT]) && !$past(ext_irq_n_i))
      else $error("external entry without enable or request");
   a_state_saved: assert property (take_o |->
      save_restore_state_o == $past(machine_state_i)) else $error("saved state wrong");
   a_state_masked: assert property (take_o |->
      machine_state_o == ($past(machine_state_i) & ~`SAPX_MS_CLR_MASK))
      else $error("entry state mask wrong");
   a_fetch_wins: assert property (ce_i && fetch_exec_viol_i |=>
      take_o && kind_o == `SAPX_K_FETCH) else $error("fetch fault not served first");
   a_handler_form: assert property (take_o |->
      handler_addr_o[31:16] == $past(vector_prefix_i[31:16]) && handler_addr_o[3:0] == 4'h0)
      else $error("handler address form wrong");
   a_ext_ack_kind: assert property (ext_ack_o |-> take_o && kind_o == `SAPX_K_EXT)
      else $error("acknowledge without external entry");
   a_ext_keeps_syndrome: assert property (ext_ack_o |->
      $stable(syndrome_reg_o) && $stable(fault_address_reg_o))
      else $error("external entry touched syndrome or fault address");
   a_ext_offset_pick: assert property (ext_ack_o && $past(autovector_n_i) |->
      handler_addr_o[15:4] == $past(vector_offset_in_i)) else $error("supplied offset not used");
endmodule
bind sapx_exc sapx_exc_chk i_chk (.clk_i, .rst_i, .ce_i, .machine_state_i, .vector_prefix_i,
   .fetch_exec_viol_i, .ext_irq_n_i, .autovector_n_i, .vector_offset_in_i, .take_o, .ext_ack_o,
   .kind_o, .save_restore_state_o, .machine_state_o, .syndrome_reg_o, .fault_address_reg_o,
   .handler_addr_o);

// File: sapx_irq_model.sv
`timescale 1ns/1ns
// Far-side interrupt controller: holds a level request until the core acknowledges
module sapx_irq_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic avec_i,
   input wire logic [11:0] offset_i,
   input wire logic ack_i,
   output logic ext_irq_n_o,
   output logic autovector_n_o,
   output logic [11:0] vector_offset_o
);
   initial begin
      ext_irq_n_o = 1'b1;
      autovector_n_o = 1'b1;
      vector_offset_o = 12'h000;
   end
   always @(posedge clk_i) begin
      if (ext_irq_n_o && req_i) begin
         ext_irq_n_o <= 1'b0;
         autovector_n_o <= ~avec_i;
         vector_offset_o <= offset_i;
      end else if (!ext_irq_n_o && ack_i) begin
         // Released lines flip so a late sample cannot match by luck
         ext_irq_n_o <= 1'b1;
         autovector_n_o <= ~autovector_n_o;
         vector_offset_o <= ~vector_offset_o;
      end
   end
endmodule

// File: testbench.sv
`timescale 1ns/1ns
`include "sapx_consts.vh"
module testbench;
   localparam logic [31:0] sy_st = 32'h1 << `SAPX_SY_ST_BIT, sy_spe = 32'h1 << `SAPX_SY_SPE_BIT;
   localparam logic [31:0] sy_vl = 32'h1 << `SAPX_SY_VAR_LENGTH_INSTR_FLAG_BIT, sy_bo = 32'h1 << `SAPX_SY_BO_BIT;
   localparam logic [31:0] sy_ilk = 32'h1 << `SAPX_SY_ILK_BIT, sy_mif = 32'h1 << `SAPX_SY_MIF_BIT;
   localparam logic [31:0] sy_pil = 32'h1 << `SAPX_SY_PIL_BIT, sy_ppr = 32'h1 << `SAPX_SY_PPR_BIT;
   localparam logic [31:0] sy_ptr = 32'h1 << `SAPX_SY_PTR_BIT, sy_puo = 32'h1 << `SAPX_SY_PUO_BIT;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [38:0] cv = '0;
   logic [31:0] machine_state_i = '0, vector_prefix_i = 32'h8000_0000;
   logic [31:0] instr_addr_i = '0, next_addr_i = '0, data_addr_i = '0;
   logic [31:0] offs [1:5] = '{32'h100, 32'h200, 32'h300, 32'h400, 32'h500};
   logic req = 1'b0, avec = 1'b0, ext_irq_n_i, autovector_n_i, take_o, ext_ack_o;
   logic [11:0] vector_offset_in_i;
   logic [2:0] kind_o;
   logic [31:0] save_restore_pc_o, save_restore_state_o, machine_state_o;
   logic [31:0] syndrome_reg_o, fault_address_reg_o, handler_addr_o, fa_exp = '0, syn_exp = '0;
   int err_count = 0, check_count = 0;
   sapx_exc i_dut (.clk_i, .rst_i, .ce_i(1'b1), .machine_state_i, .vector_prefix_i,
      .data_fault_offset_i(offs[4]), .fetch_fault_offset_i(offs[1]), .ext_irq_offset_i(offs[5]),
      .align_offset_i(offs[3]), .program_offset_i(offs[2]), .instr_addr_i, .next_addr_i,
      .data_addr_i, .is_store_i(cv[0]), .is_vector_i(cv[1]), .is_var_len_i(cv[2]),
      .data_access_viol_i(cv[3]), .data_misaligned_i(cv[4]), .data_cross_page_i(cv[5]),
      .first_page_little_i(cv[6]), .second_page_little_i(cv[7]), .is_dcache_lock_op_i(cv[8]),
      .is_icache_lock_op_i(cv[9]), .fetch_exec_viol_i(cv[10]), .instr_cross_page_i(cv[11]),
      .first_page_var_len_i(cv[12]), .second_page_var_len_i(cv[13]),
      .fetch_page_var_len_i(cv[14]), .fetch_page_little_i(cv[15]), .flow_change_i(cv[16]),
      .target_odd_half_i(cv[17]), .multiword_op_i(cv[18]), .word_resv_op_i(cv[19]),
      .half_resv_op_i(cv[20]), .word_aligned_i(cv[21]), .half_aligned_i(cv[22]),
      .vector_misaligned_i(cv[23]), .line_zero_op_i(cv[24]), .dcache_enabled_i(cv[25]),
      .page_write_through_i(cv[26]), .page_inhibited_i(cv[27]), .illegal_class_i(cv[28]),
      .reg_move_i(cv[29]), .reg_undefined_i(cv[30]), .special_reg_number_i(10'h020),
      .dev_reg_undefined_i(cv[31]), .not_implemented_i(cv[32]), .privileged_op_i(cv[33]),
      .trap_op_i(cv[34]), .trap_cond_met_i(cv[35]), .trap_debug_en_i(cv[36]),
      .unimpl_op_i(cv[37]), .float_op_i(cv[38]), .ext_irq_n_i, .autovector_n_i,
      .vector_offset_in_i, .take_o, .ext_ack_o, .kind_o, .save_restore_pc_o,
      .save_restore_state_o, .machine_state_o, .syndrome_reg_o, .fault_address_reg_o,
      .handler_addr_o);
   sapx_irq_model i_ctl (.clk_i, .req_i(req), .avec_i(avec), .offset_i(12'hA5C),
      .ack_i(ext_ack_o), .ext_irq_n_o(ext_irq_n_i), .autovector_n_o(autovector_n_i),
      .vector_offset_o(vector_offset_in_i));
   initial forever #25 clk_i = ~clk_i;
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task finish_test;
      if (err_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One entry: conditions applied for one edge, results judged on the next falling edge
   task fire(input logic [38:0] c, input logic [31:0] ms, input logic [2:0] k,
      input logic [31:0] syn, input logic upd);
      logic [31:0] hnd;
      instr_addr_i += 32'h104;
      data_addr_i += 32'h208;
      next_addr_i = instr_addr_i + 32'h4;
      vector_prefix_i += 32'h0001_0000;
      offs[k] += 32'h10;
      cv = c;
      machine_state_i = ms;
      if (upd) fa_exp = data_addr_i;
      syn_exp = syn;
      hnd = {vector_prefix_i[31:16], offs[k][15:4], 4'h0};
      @(negedge clk_i);
      check(take_o, 1'b1);
      check(kind_o, k);
      check(syndrome_reg_o, syn);
      check(fault_address_reg_o, fa_exp);
      check(save_restore_pc_o, instr_addr_i);
      check(save_restore_state_o, ms);
      check(machine_state_o, ms & ~`SAPX_MS_CLR_MASK);
      check(handler_addr_o, hnd);
   endtask
   task quiet(input logic [38:0] c, input logic [31:0] ms);
      cv = c;
      machine_state_i = ms;
      @(negedge clk_i);
      check(take_o, 1'b0);
   endtask
   // Request waits while disabled, then is taken once enabled
   task ext_irq(input logic av);
      int n;
      cv = '0;
      machine_state_i = '0;
      @(negedge clk_i);
      req = 1'b1;
      avec = av;
      @(negedge clk_i);
      req = 1'b0;
      repeat (3) begin
         @(negedge clk_i);
         check(take_o, 1'b0);
      end
      machine_state_i = 32'h0000_8000;
      n = 0;
      while (ext_ack_o !== 1'b1 && n < 8) begin
         @(negedge clk_i);
         n++;
      end
      check(ext_ack_o, 1'b1);
      check(kind_o, `SAPX_K_EXT);
      check(save_restore_pc_o, next_addr_i);
      check(syndrome_reg_o, syn_exp);
      check(fault_address_reg_o, fa_exp);
      check(handler_addr_o, {vector_prefix_i[31:16], av ? offs[5][15:4] : 12'hA5C, 4'h0});
   endtask
   initial begin
      #(400 * 50);
      err_count++;
      finish_test;
   end
   initial begin
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      fire(39'h00_0000_000B, 32'hFFFF_FFFF, `SAPX_K_DATA, sy_st | sy_spe, 1'b1);
      fire(39'h00_0000_0074, 32'h0000_4000, `SAPX_K_DATA, sy_bo | sy_vl, 1'b1);
      fire(39'h00_0000_0201, 32'h0000_4000, `SAPX_K_DATA, sy_ilk | sy_st, 1'b0);
      fire(39'h00_0000_0408, 32'h0000_0000, `SAPX_K_FETCH, 32'h0, 1'b0);
      fire(39'h00_0003_0000, 32'h0000_0000, `SAPX_K_FETCH, sy_mif, 1'b0);
      fire(39'h00_0000_C000, 32'h0000_0000, `SAPX_K_FETCH, sy_bo, 1'b0);
      fire(39'h00_0004_0001, 32'h0000_0000, `SAPX_K_ALIGN, sy_st, 1'b1);
      fire(39'h00_0010_0000, 32'h0000_0000, `SAPX_K_ALIGN, 32'h0, 1'b1);
      fire(39'h00_0700_0000, 32'h0000_0000, `SAPX_K_ALIGN, 32'h0, 1'b1);
      fire(39'h00_0100_0000, 32'h0000_0000, `SAPX_K_ALIGN, 32'h0, 1'b1);
      fire(39'h02_1000_0000, 32'h0000_4000, `SAPX_K_PROG, sy_pil, 1'b0);
      fire(39'h00_2000_0000, 32'h0000_4000, `SAPX_K_PROG, sy_ppr, 1'b0);
      fire(39'h0C_0000_0000, 32'h0000_0000, `SAPX_K_PROG, sy_ptr, 1'b0);
      fire(39'h20_0000_0000, 32'h0000_0000, `SAPX_K_PROG, sy_puo, 1'b0);
      quiet(39'h1C_0000_0000, 32'h0000_0000);
      quiet(39'h00_0000_0201, 32'h0000_0000);
      ext_irq(1'b1);
      ext_irq(1'b0);
      finish_test;
   end
endmodule
